// File: core/cie_pkg.sv
// Constants, types and carriers for the interrupt entry and return unit.
// Assumes the clock is the high-frequency system clock of the core.
package cie_pkg;

   // Software trap opcode, also returned for unimplemented fetches.
   localparam logic [7:0]  SOFT_TRAP_OP = 8'hff;

   // Fetch areas that raise an address trap reset.
   localparam logic [15:0] SFR_LO = 16'h0000;
   localparam logic [15:0] SFR_HI = 16'h003f;
   localparam logic [15:0] RAM_LO = 16'h0040;
   localparam logic [15:0] RAM_HI = 16'h023f;
   localparam logic [15:0] DBR_LO = 16'h1f80;
   localparam logic [15:0] DBR_HI = 16'h1fff;

   // Stack frame: five bytes, index 0 pushed first.
   localparam int          FRAME_BYTES = 5;
   localparam logic [2:0]  IDX_FIRST   = 3'h0;
   localparam logic [2:0]  IDX_LAST    = 3'h4;
   localparam logic [15:0] SP_STEP     = 16'h0001;

   // Status word layout.
   localparam int          PSW_IMF_BIT = 15;
   localparam int          PSW_RBS_LSB = 8;

   // Reset values.
   localparam logic        IMF_RST  = 1'b0;
   localparam logic [3:0]  RBS_RST  = 4'h0;
   localparam logic [15:0] SP_RST   = 16'h023f;

   // Longest wait from latch set to acceptance, in fc periods.
   localparam int          ACCEPT_MAX_FC  = 62;
   localparam int          CLK_PER_FC     = 1;
   localparam int          ACCEPT_MAX_CYC = ACCEPT_MAX_FC * CLK_PER_FC;

   typedef enum logic [1:0] {
      CIE_IDLE = 2'b00,
      CIE_PUSH = 2'b01,
      CIE_POP  = 2'b11
   } cie_state_e;

   typedef enum logic [1:0] {
      CIE_KIND_MASK = 2'b00,
      CIE_KIND_NMI  = 2'b01,
      CIE_KIND_SWI  = 2'b10
   } cie_kind_e;

   // Saved context as it sits on the stack, top byte pushed first.
   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] program_status_word;
      logic [7:0]  aux;
   } cie_frame_s;

endpackage

// File: core/cie_core.sv
// Interrupt entry and return sequencing for an 8-bit CPU core.
// Assumes a priority encoder in front and an instruction sequencer that
// stalls while busy_out is high; stack memory reads combinationally.
`timescale 1ns/100ps

module cie_core #(
   parameter int          NEST_W = 4,
   parameter logic [15:0] RAM_TOP = cie_pkg::RAM_HI
) (
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        instr_last_in,
   input  wire logic        maskable_return_op_in,
   input  wire logic        nonmaskable_return_op_in,
   input  wire logic        soft_trap_op_in,
   input  wire logic        irq_req_in,
   input  wire logic        nmi_req_in,
   input  wire logic        auto_bank_in,
   input  wire logic [3:0]  vector_bank_in,
   input  wire logic [15:0] return_pc_in,
   input  wire logic [7:0]  cpu_flags_in,
   input  wire logic        imf_write_in,
   input  wire logic        imf_wdata_in,
   input  wire logic        sp_load_in,
   input  wire logic [15:0] sp_load_val_in,
   input  wire logic [7:0]  stack_rdata_in,
   input  wire logic        fetch_req_in,
   input  wire logic [15:0] fetch_addr_in,
   input  wire logic [7:0]  mem_rdata_in,
   input  wire logic        mem_hit_in,
   input  wire logic        single_chip_in,
   output logic             busy_out,
   output logic             entry_done_out,
   output logic [1:0]       entry_kind_out,
   output logic             return_done_out,
   output logic [15:0]      pc_out,
   output logic [7:0]       cpu_flags_out,
   output logic             master_irq_enable_out,
   output logic [3:0]       reg_bank_select_out,
   output logic [NEST_W-1:0] nest_count_out,
   output logic             nest_flag_out,
   output logic             nmi_active_out,
   output logic             soft_trap_irq_out,
   output logic             swi_nop_out,
   output logic             addr_error_out,
   output logic             stack_we_out,
   output logic [15:0]      stack_addr_out,
   output logic [7:0]       stack_wdata_out,
   output logic [15:0]      sp_out,
   output logic [7:0]       fetch_data_out,
   output logic             addr_trap_reset_out
);

   initial begin
      if (NEST_W < 1 || NEST_W > 8) begin
         $error("cie_core: NEST_W must lie in 1..8");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State and decode

   cie_pkg::cie_state_e  state_q;
   cie_pkg::cie_kind_e   kind_q;
   cie_pkg::cie_frame_s  frame_q;
   cie_pkg::cie_frame_s  popped;
   logic [2:0]           idx_q;
   logic [15:0]          sp_q;
   logic                 imf_q;
   logic [3:0]           rbs_q;
   logic [3:0]           bank_q;
   logic                 bank_sw_q;
   logic                 nmi_act_q;
   logic                 imf_clr_q;
   logic                 nonmaskable_return_op_q;
   logic                 bad_fetch_q;
   logic [NEST_W-1:0]    nest_q;
   logic [39:0]          frame_bits;
   logic                 sample;
   logic                 is_ret;
   logic                 take_swi;
   logic                 take_nmi;
   logic                 take_irq;
   logic                 go_push;
   logic                 go_pop;
   logic                 push_end;
   logic                 pop_end;
   logic [5:0]           bsel;

   // Requests are looked at only in an instruction's final cycle.
   assign sample   = (state_q == cie_pkg::CIE_IDLE) && instr_last_in;
   assign is_ret   = maskable_return_op_in || nonmaskable_return_op_in;
   assign take_swi = sample && soft_trap_op_in && !nmi_act_q;
   assign take_nmi = sample && !is_ret && !take_swi && nmi_req_in;
   assign take_irq = sample && !is_ret && !take_swi && !nmi_req_in &&
                     irq_req_in && imf_q;
   assign go_push  = take_swi || take_nmi || take_irq;
   assign go_pop   = sample && is_ret && !soft_trap_op_in;
   assign push_end = (state_q == cie_pkg::CIE_PUSH) &&
                     (idx_q == cie_pkg::IDX_LAST);
   assign pop_end  = (state_q == cie_pkg::CIE_POP) &&
                     (idx_q == cie_pkg::IDX_FIRST);

   // Byte lane of the frame for the current index; index 0 is the top.
   assign bsel       = 6'(8 * (cie_pkg::FRAME_BYTES - 1 - int'(idx_q)));
   assign frame_bits = frame_q;
   assign popped     = {stack_rdata_in, frame_q.pc[7:0], frame_q.program_status_word,
                        frame_q.aux};

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: idle, push five bytes, or pop five bytes

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= cie_pkg::CIE_IDLE;
         idx_q   <= 3'h0;
      end else begin
         unique case (state_q)
            cie_pkg::CIE_IDLE: begin
               if (go_push) begin
                  state_q <= cie_pkg::CIE_PUSH;
                  idx_q   <= cie_pkg::IDX_FIRST;
               end else if (go_pop) begin
                  state_q <= cie_pkg::CIE_POP;
                  idx_q   <= cie_pkg::IDX_LAST;
               end
            end
            cie_pkg::CIE_PUSH: begin
               if (push_end) begin
                  state_q <= cie_pkg::CIE_IDLE;
               end else begin
                  idx_q <= idx_q + 3'h1;
               end
            end
            cie_pkg::CIE_POP: begin
               if (pop_end) begin
                  state_q <= cie_pkg::CIE_IDLE;
               end else begin
                  idx_q <= idx_q - 3'h1;
               end
            end
         endcase
      end
   end

   // Frame capture at acceptance, and byte gathering while popping.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         frame_q   <= '0;
         kind_q    <= cie_pkg::CIE_KIND_MASK;
         bank_q    <= cie_pkg::RBS_RST;
         bank_sw_q <= 1'b0;
         nonmaskable_return_op_q    <= 1'b0;
      end else if (go_push) begin
         // Status word carries the enable and bank select.
         frame_q.pc  <= return_pc_in;
         frame_q.program_status_word <= {imf_q, 3'h0, rbs_q, cpu_flags_in};
         frame_q.aux <= {6'h00, nmi_act_q, imf_clr_q};
         kind_q      <= take_swi ? cie_pkg::CIE_KIND_SWI :
                        take_nmi ? cie_pkg::CIE_KIND_NMI :
                                   cie_pkg::CIE_KIND_MASK;
         bank_q      <= vector_bank_in;
         bank_sw_q   <= auto_bank_in;
      end else if (go_pop) begin
         nonmaskable_return_op_q <= nonmaskable_return_op_in;
      end else if (state_q == cie_pkg::CIE_POP && !pop_end) begin
         frame_q[bsel +: 8] <= stack_rdata_in;
      end
   end

   // Stack pointer: down once per pushed byte, up once per popped byte.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sp_q <= cie_pkg::SP_RST;
      end else if (state_q == cie_pkg::CIE_PUSH) begin
         sp_q <= sp_q - cie_pkg::SP_STEP;
      end else if (state_q == cie_pkg::CIE_POP) begin
         sp_q <= sp_q + cie_pkg::SP_STEP;
      end else if (sp_load_in) begin
         sp_q <= sp_load_val_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Master enable, bank select and nesting state

   // Enable: cleared after the save, set by maskable returns, restored from the frame by non-maskable returns
   // unless software cleared it during NMI service, or written by software.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         imf_q <= cie_pkg::IMF_RST;
      end else if (push_end) begin
         imf_q <= 1'b0;
      end else if (pop_end && !nonmaskable_return_op_q) begin
         imf_q <= 1'b1;
      end else if (pop_end) begin
         imf_q <= popped.program_status_word[cie_pkg::PSW_IMF_BIT] && !imf_clr_q;
      end else if (imf_write_in) begin
         imf_q <= imf_wdata_in;
      end
   end

   // Bank select switches on entry and comes back from the frame.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rbs_q <= cie_pkg::RBS_RST;
      end else if (push_end && bank_sw_q) begin
         rbs_q <= bank_q;
      end else if (pop_end) begin
         rbs_q <= popped.program_status_word[cie_pkg::PSW_RBS_LSB +: 4];
      end
   end

   // NMI activity and the record of software clearing the enable in it.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         nmi_act_q <= 1'b0;
         imf_clr_q <= 1'b0;
      end else if (go_push && !take_irq) begin
         nmi_act_q <= 1'b1;
         imf_clr_q <= 1'b0;
      end else if (pop_end) begin
         nmi_act_q <= popped.aux[1];
         imf_clr_q <= popped.aux[0];
      end else if (nmi_act_q && imf_write_in && !imf_wdata_in) begin
         imf_clr_q <= 1'b1;
      end
   end

   // Nesting depth, saturating at both ends.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         nest_q <= '0;
      end else if (go_push && nest_q != '1) begin
         nest_q <= nest_q + 1'b1;
      end else if (pop_end && nest_q != '0) begin
         nest_q <= nest_q - 1'b1;
      end
   end

   // Restored program counter and flags for the sequencer.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pc_out        <= 16'h0000;
         cpu_flags_out <= 8'h00;
      end else if (pop_end) begin
         pc_out        <= popped.pc;
         cpu_flags_out <= popped.program_status_word[7:0];
      end
   end

   // Event pulses toward the sequencer.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         entry_done_out    <= 1'b0;
         return_done_out   <= 1'b0;
         soft_trap_irq_out <= 1'b0;
         swi_nop_out       <= 1'b0;
         addr_error_out    <= 1'b0;
      end else begin
         entry_done_out    <= push_end;
         return_done_out   <= pop_end;
         soft_trap_irq_out <= take_swi;
         swi_nop_out       <= sample && soft_trap_op_in && nmi_act_q;
         addr_error_out    <= take_swi && bad_fetch_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetch path: trap byte substitution and address trap reset

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fetch_data_out      <= 8'h00;
         bad_fetch_q         <= 1'b0;
         addr_trap_reset_out <= 1'b0;
      end else if (fetch_req_in) begin
         bad_fetch_q    <= single_chip_in && !mem_hit_in;
         fetch_data_out <= (single_chip_in && !mem_hit_in) ?
                           cie_pkg::SOFT_TRAP_OP : mem_rdata_in;
         addr_trap_reset_out <= (fetch_addr_in <= cie_pkg::SFR_HI) ||
            (fetch_addr_in >= cie_pkg::RAM_LO && fetch_addr_in <= RAM_TOP) ||
            (fetch_addr_in >= cie_pkg::DBR_LO &&
             fetch_addr_in <= cie_pkg::DBR_HI);
      end else begin
         addr_trap_reset_out <= 1'b0;
      end
   end

   // Stack port: push writes at SP then steps down, pop steps up then reads.
   assign stack_we_out    = (state_q == cie_pkg::CIE_PUSH);
   assign stack_addr_out  = stack_we_out ? sp_q : sp_q + cie_pkg::SP_STEP;
   assign stack_wdata_out = frame_bits[bsel +: 8];
   assign busy_out        = (state_q != cie_pkg::CIE_IDLE);
   assign entry_kind_out  = kind_q;
   assign master_irq_enable_out = imf_q;
   assign reg_bank_select_out   = rbs_q;
   assign nest_count_out  = nest_q;
   assign nest_flag_out   = (nest_q != '0);
   assign nmi_active_out  = nmi_act_q;
   assign sp_out          = sp_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   logic [7:0] wait_q;

   // Cycles a taken-able maskable request has waited in idle.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wait_q <= 8'h00;
      end else if (irq_req_in && imf_q && !busy_out && !go_push) begin
         wait_q <= wait_q + 8'h01;
      end else begin
         wait_q <= 8'h00;
      end
   end

   a_imf_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (sample && !imf_q && !nmi_req_in && !soft_trap_op_in)
      |=> state_q != cie_pkg::CIE_PUSH)
      else $error("maskable request taken with enable clear");
   a_push_frame: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      go_push |=> stack_we_out [*5] ##1 !stack_we_out)
      else $error("entry did not write five stack bytes");
   a_sp_return: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      go_pop |=> ##5 sp_q == $past(sp_q, 6) + 16'h0005)
      else $error("return did not step stack pointer by five");
   a_maskable_return_op_imf: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (pop_end && !nonmaskable_return_op_q) |=> imf_q && return_done_out)
      else $error("maskable return left enable clear");
   a_nonmaskable_return_op_imf: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (pop_end && nonmaskable_return_op_q && imf_clr_q) |=> !imf_q)
      else $error("nmi return set enable after software cleared it");
   a_bank_back: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      pop_end |=> rbs_q == $past(popped.program_status_word[11:8]))
      else $error("return did not restore bank select");
   a_bank_entry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (go_push && auto_bank_in) |=> ##5 rbs_q == $past(vector_bank_in, 6))
      else $error("entry did not switch bank");
   a_swi_top: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      take_swi |=> soft_trap_irq_out && kind_q == cie_pkg::CIE_KIND_SWI)
      else $error("trap instruction not taken first");
   a_swi_nop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (sample && soft_trap_op_in && nmi_act_q) |=> !soft_trap_irq_out)
      else $error("trap raised during nmi service");
   a_ff_fetch: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (fetch_req_in && single_chip_in && !mem_hit_in)
      |=> fetch_data_out == 8'hff)
      else $error("unimplemented fetch not replaced by trap byte");
   a_trap_sfr: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (fetch_req_in && fetch_addr_in <= 16'h003f) |=> addr_trap_reset_out)
      else $error("register area fetch did not trap");
   a_accept_wait: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wait_q <= 8'(cie_pkg::ACCEPT_MAX_CYC))
      else $error("maskable acceptance later than allowed");
   a_imf_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      push_end |=> !imf_q && entry_done_out)
      else $error("enable not cleared after entry");

endmodule

// File: bench/cie_stack_model.sv
// Stack memory model standing at the far side of the entry and return unit.
// Assumes byte writes on the rising edge and combinational reads.
`timescale 1ns/100ps
module cie_stack_model (
   input  wire logic        clk_in,
   input  wire logic        we_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   output logic [7:0]       rdata_out
);
   logic [7:0] mem [0:1023];

   // Unwritten bytes read as a pattern so stale data never passes.
   initial begin
      for (int i = 0; i < 1024; i++) begin
         mem[i] = ~i[7:0];
      end
   end

   // Byte write on the strobe.
   always @(posedge clk_in) begin
      if (we_in === 1'b1) begin
         mem[addr_in[9:0]] <= wdata_in;
      end
   end

   // Combinational read of the addressed byte.
   assign rdata_out = mem[addr_in[9:0]];
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the interrupt entry and return unit.
// Assumes the stack model answers reads combinationally.
`timescale 1ns/100ps
module tb_top;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic last, mret, nret, trap, irq, nmi, abank, imf_w, imf_d, fet, sc, hit;
   logic [3:0] vb, old_bank;
   logic [15:0] pc, faddr;
   logic [7:0] fl, mrd, srd;
   logic busy, e_done, r_done, master_irq_enable, nflag, nact, strap, snop, aerr, swe;
   logic atrap;
   logic [1:0] kind;
   logic [15:0] pc_o, saddr, sp;
   logic [7:0] fl_o, swd, fdata;
   logic [3:0] bank, nest;
   logic saw_trap, saw_nop;
   int num_errors = 0;
   int checks_done = 0;
   int seed = 24;

   always #5 clk_in = ~clk_in;

   cie_core uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .instr_last_in(last), .maskable_return_op_in(mret),
      .nonmaskable_return_op_in(nret), .soft_trap_op_in(trap),
      .irq_req_in(irq), .nmi_req_in(nmi), .auto_bank_in(abank),
      .vector_bank_in(vb), .return_pc_in(pc), .cpu_flags_in(fl),
      .imf_write_in(imf_w), .imf_wdata_in(imf_d), .sp_load_in(1'b0),
      .sp_load_val_in(16'h0000), .stack_rdata_in(srd),
      .fetch_req_in(fet), .fetch_addr_in(faddr), .mem_rdata_in(mrd),
      .mem_hit_in(hit), .single_chip_in(sc), .busy_out(busy),
      .entry_done_out(e_done), .entry_kind_out(kind),
      .return_done_out(r_done), .pc_out(pc_o), .cpu_flags_out(fl_o),
      .master_irq_enable_out(master_irq_enable), .reg_bank_select_out(bank),
      .nest_count_out(nest), .nest_flag_out(nflag), .nmi_active_out(nact),
      .soft_trap_irq_out(strap), .swi_nop_out(snop),
      .addr_error_out(aerr), .stack_we_out(swe), .stack_addr_out(saddr),
      .stack_wdata_out(swd), .sp_out(sp), .fetch_data_out(fdata),
      .addr_trap_reset_out(atrap));

   cie_stack_model stk (.clk_in(clk_in), .we_in(swe), .addr_in(saddr),
      .wdata_in(swd), .rdata_out(srd));

   // Pulse catchers, sampled before the edge's own updates land.
   always @(posedge clk_in) begin
      if (strap === 1'b1) saw_trap <= 1'b1;
      if (snop === 1'b1) saw_nop <= 1'b1;
   end

   // Compares one value and counts the result.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time,
                  what, seen, exp);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic report_and_stop();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One sampling point; bits are trap, mret, nret, nmi, irq.
   task automatic request(input logic [4:0] what);
      {trap, mret, nret, nmi, irq} = what;
      last = 1'b1;
      @(negedge clk_in);
      {trap, mret, nret, nmi, irq} = 5'h00;
      last = 1'b0;
   endtask

   // Waits, bounded, for an entry or return to complete.
   task automatic wait_done();
      int n;
      n = 0;
      while (!(e_done === 1'b1 || r_done === 1'b1)) begin
         @(negedge clk_in);
         n++;
         if (n > 20) begin
            num_errors++;
            $display("CHECK FAILED at %0t: no completion", $time);
            report_and_stop();
         end
      end
   endtask

   // Fetch addresses that must trap to reset.
   function automatic logic in_trap(input logic [15:0] a);
      return (a <= cie_pkg::SFR_HI) ||
             (a >= cie_pkg::RAM_LO && a <= cie_pkg::RAM_HI) ||
             (a >= cie_pkg::DBR_LO && a <= cie_pkg::DBR_HI);
   endfunction

   // Single write of the master enable from software.
   task automatic write_imf(input logic v);
      imf_w = 1'b1;
      imf_d = v;
      @(negedge clk_in);
      imf_w = 1'b0;
   endtask

   // Main sequence.
   initial begin
      {last, mret, nret, trap, irq, nmi, abank, imf_w, imf_d} = 9'h000;
      {fet, sc, hit, vb, pc, fl, faddr, mrd} = '0;
      {saw_trap, saw_nop} = 2'b00;
      repeat (10) @(negedge clk_in);
      reset_n_in = 1'b1;
      chk(sp, cie_pkg::SP_RST, "sp reset");
      chk(master_irq_enable, cie_pkg::IMF_RST, "enable reset");
      chk(bank, cie_pkg::RBS_RST, "bank reset");
      request(5'h01);
      chk(busy, 1'b0, "irq taken while disabled");
      write_imf(1'b1);
      for (int k = 0; k < 6; k++) begin
         pc = 16'($random(seed));
         fl = 8'($random(seed));
         vb = 4'($random(seed));
         if (vb == 4'h0) vb = 4'h1;
         abank = 1'b1;
         old_bank = bank;
         request(5'h01);
         chk(busy, 1'b1, "irq after return not taken");
         wait_done();
         chk(master_irq_enable, 1'b0, "enable after entry");
         chk(bank, vb, "bank switch");
         chk(sp, 16'h023a, "sp after entry");
         chk(nflag, 1'b1, "nest flag");
         chk(stk.mem[10'h23f], pc[15:8], "pushed pc high");
         chk(stk.mem[10'h23e], pc[7:0], "pushed pc low");
         chk(stk.mem[10'h23d], {4'h8, old_bank}, "pushed psw");
         chk(stk.mem[10'h23c], fl, "pushed flags");
         request(5'h01);
         chk(busy, 1'b0, "nested irq while disabled");
         @(negedge clk_in);
         request(5'h08);
         wait_done();
         chk(pc_o, pc, "restored pc");
         chk(fl_o, fl, "restored flags");
         chk(bank, old_bank, "restored bank");
         chk(master_irq_enable, 1'b1, "enable after return");
         chk(sp, 16'h023f, "sp after return");
         chk(nest, 4'h0, "nest after return");
      end
      // Trap taken, then ignored as a no-operation during its service.
      saw_trap = 1'b0;
      request(5'h10);
      wait_done();
      chk(saw_trap, 1'b1, "trap pulse");
      chk(kind, cie_pkg::CIE_KIND_SWI, "trap kind");
      saw_trap = 1'b0;
      saw_nop = 1'b0;
      request(5'h10);
      chk(busy, 1'b0, "trap during nmi service");
      repeat (2) @(negedge clk_in);
      chk({saw_trap, saw_nop}, 2'b01, "trap not a nop");
      request(5'h04);
      wait_done();
      chk(master_irq_enable, 1'b1, "enable after nmi return");
      // Non-maskable entry whose service clears the enable; kept short.
      request(5'h02);
      wait_done();
      chk(nact, 1'b1, "nmi active");
      write_imf(1'b0);
      request(5'h04);
      wait_done();
      chk(master_irq_enable, 1'b0, "enable kept clear");
      chk(nest, 4'h0, "nest after nmi return");
      // Fetches: corners first, then random addresses.
      fet = 1'b1;
      for (int k = 0; k < 60; k++) begin
         case (k)
            0: faddr = 16'h003f;
            1: faddr = 16'h0040;
            2: faddr = 16'h023f;
            3: faddr = 16'h0240;
            4: faddr = 16'h1f7f;
            5: faddr = 16'h1f80;
            6: faddr = 16'h1fff;
            7: faddr = 16'h2000;
            default: faddr = 16'($random(seed));
         endcase
         mrd = 8'($random(seed));
         {sc, hit} = 2'($random(seed));
         @(negedge clk_in);
         chk(fdata, (sc && !hit) ? cie_pkg::SOFT_TRAP_OP : mrd,
             "fetch data");
         chk(atrap, in_trap(faddr), "address trap");
      end
      // Substituted fetch, then the trap byte runs: address error flagged.
      sc = 1'b1;
      hit = 1'b0;
      @(negedge clk_in);
      fet = 1'b0;
      request(5'h10);
      chk(aerr, 1'b1, "address error pulse");
      wait_done();
      report_and_stop();
   end
endmodule
